//--- ldc_pkg.sv
// ldc_pkg: constants shared by the lcd display controller and its testbench
// assumes: register bus offsets are byte addresses in the cpu data space
`default_nettype none

package ldc_pkg;

   // ------------------------------------------------------------
   // register bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 10;  // data space address width
   localparam int DATA_W = 8;   // register data width

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [9:0] ADDR_PWR_CTRL = 10'h01A;  // lcd_power_control
   localparam logic [9:0] ADDR_DSP_CTRL = 10'h01B;  // lcd_display_control
   localparam logic [9:0] ADDR_BUF_LO   = 10'h200;  // first display_buffer byte
   localparam logic [9:0] ADDR_BUF_HI   = 10'h22B;  // last display_buffer byte

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_PWR_CTRL = 8'h7F;  // pump clk 111, pump on, reg on, 1.50V
   localparam logic [7:0] RST_DSP_CTRL = 8'h04;  // lcd clock tap 6, display off

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PUMP_CLK_LSB = 0;  // charge pump clock select [2:0]
   localparam int PUMP_EN_BIT  = 3;  // charge pump enable
   localparam int REG_EN_BIT   = 4;  // regulator enable
   localparam int REG_LVL_LSB  = 5;  // regulator level [6:5]
   localparam int LCD_CLK_LSB  = 0;  // lcd clock select [2:0]
   localparam int MODE_LSB     = 3;  // display mode [4:3]

   // ------------------------------------------------------------
   // buffer layout
   // ------------------------------------------------------------
   localparam int BUF_BYTES    = 40;  // display_buffer size
   localparam int ROW_BYTES    = 5;   // stored bytes per common row
   localparam int ROW_STRIDE   = 8;   // address step between rows
   localparam int MAX_COMMONS  = 6;   // most common lines
   localparam int MAX_SEGMENTS = 31;  // most segment lines
   localparam int TAP_COUNT    = 9;   // slow divider taps 0..8

   // ------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF,   // panel blank, all lines at ground
      MODE_ON,    // drive from display_buffer
      MODE_ZERO,  // all segments off
      MODE_ONE    // all segments on
   } ldc_mode_t;

   // drive level codes of one line
   localparam logic [1:0] LV_VSS  = 2'h0;  // ground
   localparam logic [1:0] LV_V1   = 2'h1;  // one third (half at 1/2 bias)
   localparam logic [1:0] LV_V2   = 2'h2;  // two thirds
   localparam logic [1:0] LV_PANEL_SUPPLY_LEVEL = 2'h3;  // full panel_supply_level

endpackage

`default_nettype wire

//--- ldc_div_if.sv
// ldc_div_if: slow divider taps passed from the divider to the controller
// assumes: both ends run on the same clk
`default_nettype none

interface ldc_div_if;
   logic [8:0] slowDividerTap;  // tap n toggles at slow clock / 2^(n+1)
   logic       slowLevel;       // undivided slow clock, registered

   // divider end
   modport src (output slowDividerTap, output slowLevel);
   // controller end
   modport snk (input slowDividerTap, input slowLevel);
endinterface

`default_nettype wire

//--- ldc_slow_divider.sv
// ldc_slow_divider: ripple-style divider of the 32 kHz slow clock
// assumes: slowClk is a level synchronous to clk, far slower than clk
`default_nettype none

module ldc_slow_divider (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // slow clock level
   input  wire logic slowClk,
   // taps toward the controller
   ldc_div_if.src    taps
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic       slowNow;  // registered slow clock level
      logic [8:0] count;    // slow clock edge counter
   } ldc_div_state_t;

   ldc_div_state_t s;       // current state
   ldc_div_state_t next_s;  // next state

   // count every rising slow clock edge
   always_comb begin
      next_s         = s;
      next_s.slowNow = slowClk;
      if (slowClk && !s.slowNow) begin
         next_s.count = s.count + 9'h001;
      end
   end

   // register the state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign taps.slowDividerTap = s.count;
   assign taps.slowLevel      = s.slowNow;

endmodule

`default_nettype wire

//--- ldc_display_controller.sv
// ldc_display_controller: lcd power control, clock taps, buffer and scan drive
// assumes: one 10 MHz clk; slowClk is a synchronous 32 kHz level
//
// How it works
// - forty byte display buffer, top at 0x22B
// - buffer writes shown on the lines one clk later
// - rows every eight bytes, byte k holds 8k+7..8k
// - pump clock code picks slow/128 ... slow/1
// - power bit 3 enables charge pump
// - power bit 4 enables regulator
// - power bits 6:5 pick regulator level
// - lcd clock code picks slow/512 ... slow/16
// - lcd clocks come from slow divider only
// - one common line per lcd clock period
// - mode bits 4:3 pick off, on, zero, one
// - build-time duty two to six commons
// - build-time bias half or third
// - build-time segment count, others idle
// - third bias uses four drive levels
//
// Chosen here: the strobed register port.
`default_nettype none

module ldc_display_controller #(
   parameter int DUTY      = 4,   // common lines in use, 2..6
   parameter int BIAS      = 3,   // 2 for 1/2 bias, 3 for 1/3 bias
   parameter int SEG_COUNT = 31   // segment lines in use, 0..31
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // slow clock
   input  wire logic        slowClk,
   // register bus
   input  wire logic [9:0]  addr,
   input  wire logic [7:0]  wrData,
   input  wire logic        wrStrobe,
   input  wire logic        rdStrobe,
   output logic      [7:0]  rdData,
   // analog power controls
   output logic             chargePumpEn,
   output logic             regulatorEn,
   output logic      [1:0]  regulatorLevel,
   output logic             chargePumpClk,
   // panel drive, two level bits per line
   output logic      [11:0] commonLine,
   output logic      [61:0] segmentLine
);

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------

   // buffer address decode
   function automatic logic bufMapped(input logic [9:0] a);
      bufMapped = (a >= ldc_pkg::ADDR_BUF_LO) && (a <= ldc_pkg::ADDR_BUF_HI)
                  && (a[2:0] < 3'(ldc_pkg::ROW_BYTES));
   endfunction

   // storage index of a row and byte
   function automatic logic [5:0] bufIndex(input logic [2:0] row, input logic [2:0] k);
      bufIndex = 6'(row * ldc_pkg::ROW_BYTES) + 6'(k);
   endfunction

   // lcd clock tap for a select code
   function automatic logic lcdTap(input logic [2:0] code, input logic [8:0] t);
      case (code)
         3'h0:    lcdTap = t[8];
         3'h4:    lcdTap = t[6];
         3'h5:    lcdTap = t[5];
         3'h6:    lcdTap = t[4];
         3'h7:    lcdTap = t[3];
         default: lcdTap = t[7];
      endcase
   endfunction

   // charge pump clock for a select code
   function automatic logic pumpTap(input logic [2:0] code, input logic [8:0] t,
                                    input logic slow);
      if (code == 3'h7) begin
         pumpTap = slow;
      end else begin
         pumpTap = t[3'h6 - code];
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  pwrCtrl;   // lcd_power_control
      logic [7:0]  dspCtrl;   // lcd_display_control
      logic [7:0]  rdData;    // read answer
      logic [2:0]  comIdx;    // common line being scanned
      logic        phase;     // frame polarity
      logic        prevTap;   // lcd clock tap one cycle ago
      logic        pumpClk;   // registered charge pump clock
      logic [11:0] comLevel;  // common drive codes
      logic [61:0] segLevel;  // segment drive codes
   } ldc_state_t;

   ldc_state_t s;       // current state
   ldc_state_t next_s;  // next state

   logic [7:0] displayBuffer [ldc_pkg::BUF_BYTES];  // display_buffer storage
   ldc_div_if  divBus ();                           // divider taps

   // ------------------------------------------------------------
   // slow clock divider
   // ------------------------------------------------------------
   ldc_slow_divider divider (
      .clk     (clk),
      .rst     (rst),
      .slowClk (slowClk),
      .taps    (divBus)
   );

   // ------------------------------------------------------------
   // buffer write port
   // ------------------------------------------------------------

   always_ff @(posedge clk) begin
      if (wrStrobe && bufMapped(addr)) begin
         displayBuffer[bufIndex(addr[5:3], addr[2:0])] <= wrData;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic       tapNow;
      logic [1:0] mode;
      logic       segOn;
      logic [7:0] segByte;
      logic [1:0] lvl;
      tapNow  = 1'b0;
      mode    = 2'h0;
      segOn   = 1'b0;
      segByte = 8'h00;
      lvl     = ldc_pkg::LV_VSS;
      next_s  = s;

      // register writes
      if (wrStrobe) begin
         if (addr == ldc_pkg::ADDR_PWR_CTRL) begin
            next_s.pwrCtrl = wrData;
         end else if (addr == ldc_pkg::ADDR_DSP_CTRL) begin
            next_s.dspCtrl = wrData;
         end
      end

      // read answer stands one cycle only
      next_s.rdData = 8'h00;
      if (rdStrobe) begin
         if (addr == ldc_pkg::ADDR_PWR_CTRL) begin
            next_s.rdData = s.pwrCtrl;
         end else if (addr == ldc_pkg::ADDR_DSP_CTRL) begin
            next_s.rdData = s.dspCtrl;
         end else if (bufMapped(addr)) begin
            next_s.rdData = displayBuffer[bufIndex(addr[5:3], addr[2:0])];
         end
      end

      next_s.pumpClk = pumpTap(s.pwrCtrl[ldc_pkg::PUMP_CLK_LSB +: 3],
                               divBus.slowDividerTap, divBus.slowLevel);

      // lcd clock from the slow divider
      tapNow         = lcdTap(s.dspCtrl[ldc_pkg::LCD_CLK_LSB +: 3], divBus.slowDividerTap);
      next_s.prevTap = tapNow;

      // advance one common per lcd clock rise
      if (tapNow && !s.prevTap) begin
         if (s.comIdx == 3'(DUTY - 1)) begin
            next_s.comIdx = 3'h0;
            next_s.phase  = !s.phase;
         end else begin
            next_s.comIdx = s.comIdx + 3'h1;
         end
      end

      mode = s.dspCtrl[ldc_pkg::MODE_LSB +: 2];

      for (int c = 0; c < ldc_pkg::MAX_COMMONS; c++) begin
         if (mode == ldc_pkg::MODE_OFF || c >= DUTY) begin
            lvl = ldc_pkg::LV_VSS;
         end else if (3'(c) == s.comIdx) begin
            lvl = s.phase ? ldc_pkg::LV_VSS : ldc_pkg::LV_PANEL_SUPPLY_LEVEL;
         end else if (BIAS == 3) begin
            lvl = s.phase ? ldc_pkg::LV_V2 : ldc_pkg::LV_V1;
         end else begin
            lvl = ldc_pkg::LV_V1;
         end
         next_s.comLevel[2*c +: 2] = lvl;
      end

      for (int g = 0; g < ldc_pkg::MAX_SEGMENTS; g++) begin
         segByte = displayBuffer[bufIndex(s.comIdx, 3'(g / 8))];
         case (mode)
            ldc_pkg::MODE_ON:  segOn = segByte[g % 8];
            ldc_pkg::MODE_ONE: segOn = 1'b1;
            default:           segOn = 1'b0;
         endcase
         if (mode == ldc_pkg::MODE_OFF || g >= SEG_COUNT) begin
            lvl = ldc_pkg::LV_VSS;
         end else if (segOn) begin
            lvl = s.phase ? ldc_pkg::LV_PANEL_SUPPLY_LEVEL : ldc_pkg::LV_VSS;
         end else if (BIAS == 3) begin
            lvl = s.phase ? ldc_pkg::LV_V1 : ldc_pkg::LV_V2;
         end else begin
            lvl = ldc_pkg::LV_V1;
         end
         next_s.segLevel[2*g +: 2] = lvl;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s         <= '0;
         s.pwrCtrl <= ldc_pkg::RST_PWR_CTRL;
         s.dspCtrl <= ldc_pkg::RST_DSP_CTRL;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdData         = s.rdData;
   assign chargePumpEn   = s.pwrCtrl[ldc_pkg::PUMP_EN_BIT];
   assign regulatorEn    = s.pwrCtrl[ldc_pkg::REG_EN_BIT];
   assign regulatorLevel = s.pwrCtrl[ldc_pkg::REG_LVL_LSB +: 2];
   assign chargePumpClk  = s.pumpClk;
   assign commonLine     = s.comLevel;
   assign segmentLine    = s.segLevel;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   pump_enable_a: assert property (wrStrobe && addr == ldc_pkg::ADDR_PWR_CTRL
      |=> chargePumpEn == $past(wrData[3])) else $error("pump enable not taken");
   reg_enable_a: assert property (wrStrobe && addr == ldc_pkg::ADDR_PWR_CTRL
      |=> regulatorEn == $past(wrData[4])) else $error("regulator enable not taken");
   reg_level_a: assert property (wrStrobe && addr == ldc_pkg::ADDR_PWR_CTRL
      |=> regulatorLevel == $past(wrData[6:5])) else $error("regulator level wrong");
   pump_tap_a: assert property (s.pwrCtrl[2:0] == 3'h0 && $stable(s.pwrCtrl)
      |=> chargePumpClk == $past(divBus.slowDividerTap[6])) else $error("pump tap wrong");
   buf_readback_a: assert property (wrStrobe && bufMapped(addr) ##1
      rdStrobe && addr == $past(addr) && !$past(rdStrobe)
      |=> rdData == $past(wrData, 2)) else $error("buffer readback wrong");
   com_range_a: assert property (s.comIdx < 3'(DUTY))
      else $error("common index beyond duty");
   display_off_a: assert property (s.dspCtrl[4:3] == 2'h0 [*2]
      |-> commonLine == 12'h000 && segmentLine == '0) else $error("off mode drives");
   seg_idle_a: assert property ((segmentLine >> (2 * SEG_COUNT)) == 62'h0)
      else $error("unused segment driven");
   com_step_a: assert property (lcdTap(s.dspCtrl[2:0], divBus.slowDividerTap) &&
      !s.prevTap |=> s.comIdx != $past(s.comIdx)) else $error("common not advanced");

   frame_flip_c: cover property (s.comIdx == 3'(DUTY - 1) ##[1:1000] s.comIdx == 3'h0);
   mode_on_c:    cover property (s.dspCtrl[4:3] == 2'h1 && segmentLine != '0);
   all_on_c:     cover property (s.dspCtrl[4:3] == 2'h3 ##1 commonLine != 12'h000);

endmodule

`default_nettype wire

//--- ldc_panel_model.sv
// ldc_panel_model: multiplexed glass panel, decoded from the line codes
// assumes: two level bits per line, codes 0 ground .. 3 full supply
`default_nettype none

module ldc_panel_model #(
   parameter int DUTY = 4,  // commons in use
   parameter int SEGS = 31  // segments wired to the glass
) (
   // panel lines
   input  wire logic [11:0] commonLine,
   input  wire logic [61:0] segmentLine,
   // decoded view
   output int               selCom,
   output int               nExtreme,
   output logic      [30:0] segOn,
   output logic      [3:0]  levelSet
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   // the selected common sits at an extreme, the rest in between
   always_comb begin
      logic [1:0] sl;
      selCom   = 0;
      nExtreme = 0;
      levelSet = 4'h0;
      for (int c = 0; c < DUTY; c++) begin
         levelSet[commonLine[2*c+:2]] = 1'b1;
         if (commonLine[2*c+:2] inside {2'h0, 2'h3}) begin
            selCom = c;
            nExtreme++;
         end
      end
      sl = commonLine[2*selCom+:2];
      // a segment lights when it stands at the far extreme from its common
      // unwired segment pins never light anything
      for (int g = 0; g < 31; g++) begin
         segOn[g] = (g < SEGS) && (segmentLine[2*g+:2] == ~sl);
      end
   end
endmodule

`default_nettype wire

//--- lcd_display_controller_test.sv
// lcd_display_controller_test: self-checking bench of the lcd controller
// assumes: ldc_pkg, ldc_div_if, the design and the panel model compiled first
`default_nettype none

module lcd_display_controller_test;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // setup
   // ------------------------------------------------------------
   localparam int DUTY  = 4;   // commons in use
   localparam int SEGS  = 20;  // segments in use
   localparam int SLOWP = 4;   // slow clock period in clk cycles

   logic        clk;
   logic        rst;
   logic [1:0]  sdiv = 2'h0;      // makes the slow clock
   wire logic   slowClk = sdiv[1];
   logic [9:0]  addr;
   logic [7:0]  wrData;
   logic        wrStrobe;
   logic        rdStrobe;
   logic [7:0]  rdData;
   logic        chargePumpEn;
   logic        regulatorEn;
   logic [1:0]  regulatorLevel;
   logic        chargePumpClk;
   logic [11:0] commonLine;
   logic [61:0] segmentLine;
   int          selCom;           // common the panel sees selected
   int          nExtreme;         // commons at an extreme level
   logic [30:0] segOn;            // lit segments
   logic [3:0]  levelSet;         // levels on the commons now
   logic [7:0]  img [6][5];       // expected buffer image
   int          fails   = 0;
   int          nChecks = 0;

   ldc_display_controller #(.DUTY(DUTY), .BIAS(3), .SEG_COUNT(SEGS)) u_dut (
      .clk, .rst, .slowClk, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
      .chargePumpEn, .regulatorEn, .regulatorLevel, .chargePumpClk, .commonLine,
      .segmentLine);
   ldc_panel_model #(.DUTY(DUTY), .SEGS(SEGS)) u_panel (
      .commonLine, .segmentLine, .selCom, .nExtreme, .segOn, .levelSet);

   // clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // slow clock at a quarter of clk
   always @(posedge clk) begin
      sdiv <= sdiv + 2'h1;
   end

   task automatic print_verdict;
      $display("checks %0d fails %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string msg);
      nChecks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask

   task automatic timeout;
      fails++;
      $display("MISMATCH t=%0t wait ran out", $time);
      print_verdict();
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      addr     <= a;
      wrData   <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask

   // read data stand in the cycle after the strobe
   task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      addr     <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1;
      chk(rdData, exp, msg);
   endtask

   // cycles between rising edges of pump clock (0) or of selCom bit 0 (1)
   task automatic period(input bit which, output int n);
      logic prev;
      logic cur;
      int   edges;
      n     = 0;
      edges = 0;
      prev  = 1'b1;
      for (int i = 0; i < 20000 && edges < 3; i++) begin
         @(negedge clk);
         cur = which ? selCom[0] : chargePumpClk;
         if (cur && !prev) edges++;
         if (edges == 2) n++;
         prev = cur;
      end
      if (edges < 3) timeout();
   endtask

   task automatic t_reset;
      rd(ldc_pkg::ADDR_PWR_CTRL, ldc_pkg::RST_PWR_CTRL, "power reset");
      rd(ldc_pkg::ADDR_DSP_CTRL, ldc_pkg::RST_DSP_CTRL, "display reset");
      @(posedge clk);
      #1;
      chk(rdData, 8'h00, "read data ends");
      chk({chargePumpEn, regulatorEn, regulatorLevel}, 4'hF, "power outs");
      chk({commonLine, segmentLine}, 74'h0, "lines off");
      rd(10'h01C, 8'h00, "unmapped");
   endtask

   task automatic t_power;
      logic [7:0] v [4] = '{8'h00, 8'h28, 8'h50, 8'h7F};
      foreach (v[i]) begin
         wr(ldc_pkg::ADDR_PWR_CTRL, v[i]);
         @(negedge clk);
         chk({chargePumpEn, regulatorEn, regulatorLevel},
             {v[i][3], v[i][4], v[i][6:5]}, "power outs");
         rd(ldc_pkg::ADDR_PWR_CTRL, v[i], "power read");
      end
   endtask

   // gaps in the row map must not alias onto stored bytes
   task automatic t_buffer;
      for (int r = 0; r < 6; r++) begin
         for (int k = 0; k < 5; k++) begin
            img[r][k] = 8'(r * 16 + k) ^ 8'hA5;
            wr(10'(ldc_pkg::ADDR_BUF_LO + r * 8 + k), img[r][k]);
         end
      end
      wr(10'h205, 8'hFF);
      wr(10'h22C, 8'hFF);
      rd(ldc_pkg::ADDR_BUF_HI, img[5][3], "buffer top");
      rd(10'h211, img[2][1], "buffer row");
      rd(10'h205, 8'h00, "row gap");
      rd(10'h22C, 8'h00, "past top");
      // write then read with no gap
      img[2][2] = 8'h5A;
      @(posedge clk);
      addr     <= 10'h212;
      wrData   <= 8'h5A;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1;
      chk(rdData, 8'h5A, "write then read");
   endtask

   // follow two frames and compare the lit segments of every common
   task automatic t_scan(input logic [1:0] mode);
      logic [23:0] row;
      logic [30:0] exp;
      logic [3:0]  seen;
      logic [3:0]  lv;
      int          prev;
      seen = 4'h0;
      lv   = 4'h0;
      wr(ldc_pkg::ADDR_DSP_CTRL, {3'h0, mode, 3'h7});
      repeat (3) @(negedge clk);
      for (int s = 0; s < 2 * DUTY; s++) begin
         prev = selCom;
         for (int i = 0; i < 400 && selCom == prev; i++) begin
            @(negedge clk);
            lv |= levelSet;
         end
         if (selCom == prev) timeout();
         row = {img[selCom][2], img[selCom][1], img[selCom][0]};
         exp = (mode == 2'h1) ? 31'(row[SEGS-1:0]) :
               (mode == 2'h3) ? (31'h1 << SEGS) - 31'h1 : 31'h0;
         seen[selCom[1:0]] = 1'b1;
         chk(segOn, exp, "lit segments");
         chk(nExtreme, 1, "selected commons");
         chk({commonLine[11:8], segmentLine[61:40]}, 0, "idle lines");
      end
      chk(seen, 4'hF, "commons visited");
      chk(lv, 4'hF, "drive levels");
   endtask

   task automatic t_rewrite;
      img[1][1] = 8'h3C;
      wr(10'h209, 8'h3C);
      t_scan(2'h1);
   endtask

   task automatic t_clocks;
      int n;
      int t;
      for (int c = 0; c < 8; c++) begin
         t = (c == 0) ? 8 : (c < 4) ? 7 : 10 - c;
         wr(ldc_pkg::ADDR_DSP_CTRL, {3'h0, 2'h1, 3'(c)});
         period(1'b1, n);
         chk(n, 2 * (2 ** (t + 1)) * SLOWP, "lcd clock");
         wr(ldc_pkg::ADDR_PWR_CTRL, {4'h7, 1'b1, 3'(c)});
         period(1'b0, n);
         chk(n, (c == 7) ? SLOWP : (2 ** (7 - c)) * SLOWP, "pump clock");
      end
   endtask

   task automatic t_off;
      wr(ldc_pkg::ADDR_DSP_CTRL, 8'h07);
      repeat (3) @(negedge clk);
      chk({commonLine, segmentLine}, 74'h0, "display off");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst      = 1'b1;
      addr     = 10'h000;
      wrData   = 8'h00;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_power();
      t_buffer();
      t_scan(2'h1);
      t_scan(2'h2);
      t_scan(2'h3);
      t_rewrite();
      t_clocks();
      t_off();
      print_verdict();
   end
endmodule

`default_nettype wire
